// file: shared/adc_path_map.svh
// Contract
// - channel picks reference one or two
// - channel measures positive minus negative input
// - four differential channels, zero to three
// - seven single-ended channels, zero to six
// - input field code equals input index
// - fixed 16x or bypass, then 1x-8x
// - total gain is product, 1x to 128x
// - gain held per channel configuration
// - gain 16 or more forces input buffer
// - crystal detected stops internal oscillator
// - eight rates, default 214.65 samples per second
// - rate bases are clock over 266240, 16640
// - rate held per channel
// - scanning divides rate by channel count
// - sinc4 line rejection only at slow rates
// - filter timing scales with converter clock
// - seven pins drive or sample levels
// - calibration runs in hardware, no interruption
// - calibration covers channels zero to three
// - two-bit calibration mode selects four modes
`ifndef ADC_PATH_MAP_SVH
`define ADC_PATH_MAP_SVH
`define NUM_CH 7
`define NUM_DIFF_CH 4
`define IDX_INCTL 6'h00
`define IDX_CFG 6'h08
`define IDX_CLK 6'h10
`define IDX_CAL 6'h11
`define IDX_SCAN 6'h12
`define IDX_GOUT 6'h13
`define IDX_GOE 6'h14
`define IDX_GIN 6'h15
`define IDX_STAT 6'h16
`define RST_INCTL 7'h00
`define RST_CFG 7'h70
`define RST_SCAN 8'h00
`define FIELD_W 7
`define SCAN_LAST_LSB 4
`define GAIN_FIXED_MIN 3'h4
`define RATE_SLOW_MAX 3'h3
`define CONV_SLOW_TICKS 266240
`define CONV_FAST_TICKS 16640
`define CLK_MHZ_X10K 2000000
`define CONV_CLK_HZ_X10 35717000
`endif

// file: shared/adc_path_pkg.sv
package adc_path_pkg;
   typedef struct packed {
      logic ref_two;
      logic [2:0] pos;
      logic [2:0] neg;
   } chan_in_t;
   typedef struct packed {
      logic [2:0] rate;
      logic [2:0] gain;
      logic buf_en;
   } chan_cfg_t;
   typedef struct packed {
      logic [2:0] chan;
      chan_in_t sel;
      logic fixed_on;
      logic [1:0] programmable_gain_stage;
      logic buf_on;
      logic [2:0] rate;
      logic line_reject;
      logic [1:0] cal_mode;
      logic cal_active;
   } path_t;
   typedef enum logic [1:0] {
      CAL_OFF, CAL_OFS_CORR, CAL_BOTH_CORR, CAL_BOTH_EST
   } cal_mode_t;
   typedef enum {SEQ_IDLE, SEQ_CONV} seq_t;
endpackage

// file: core/adc_path_cfg.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "adc_path_map.svh"
module adc_path_cfg #(
   parameter int TICK_DIV = (`CLK_MHZ_X10K * 1000 + `CONV_CLK_HZ_X10 / 2) / `CONV_CLK_HZ_X10,
   parameter int CONV_SLOW = `CONV_SLOW_TICKS,
   parameter int CONV_FAST = `CONV_FAST_TICKS
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic XTAL_SEEN,
   input wire logic [6:0] GPIO_IN,
   output logic [6:0] GPIO_OUT,
   output logic [6:0] GPIO_OE,
   output logic INT_OSC_ON,
   output logic EXT_CLK_USE,
   output adc_path_pkg::path_t PATH,
   output logic CONV_DONE
);
   function automatic logic gain_fixed(input logic [2:0] g);
      gain_fixed = g >= `GAIN_FIXED_MIN;
   endfunction

   function automatic logic buf_need(input adc_path_pkg::chan_cfg_t c);
      buf_need = gain_fixed(c.gain) | c.buf_en;
   endfunction

   function automatic logic [21:0] conv_len(input logic [2:0] r);
      logic [21:0] b;
      b = r[2] ? 22'(CONV_FAST) : 22'(CONV_SLOW);
      conv_len = b << (2'h3 - r[1:0]);
   endfunction

   // first above last wraps through six, so channel seven is never reached
   function automatic logic [2:0] next_chan(input logic [2:0] c, input logic [2:0] f, input logic [2:0] l);
      if (c == l) begin
         next_chan = f;
      end else if (c >= 3'h6) begin
         next_chan = 3'h0;
      end else begin
         next_chan = 3'(c + 3'h1);
      end
   endfunction

   function automatic logic is_inctl(input logic [5:0] i);
      is_inctl = i < 6'(`NUM_CH);
   endfunction

   function automatic logic is_cfg(input logic [5:0] i);
      is_cfg = i >= `IDX_CFG && i < `IDX_CFG + 6'(`NUM_CH);
   endfunction

   // register file
   adc_path_pkg::chan_in_t inctl_q [`NUM_CH];
   adc_path_pkg::chan_in_t inctl_d [`NUM_CH];
   adc_path_pkg::chan_cfg_t cfg_q [`NUM_CH];
   adc_path_pkg::chan_cfg_t cfg_d [`NUM_CH];
   logic [1:0] clk_q, clk_d;
   logic [1:0] cal_q, cal_d;
   logic [7:0] scan_q, scan_d;
   logic [6:0] gout_q, gout_d;
   logic [6:0] goe_q, goe_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic slverr_q, slverr_d;

   // pin synchronisers
   logic [7:0] s1_q, s2_q, s3_q;
   logic [7:0] pin_q, pin_d;

   // sequencer
   adc_path_pkg::seq_t st_q, st_d;
   logic [2:0] ch_q, ch_d;
   logic [21:0] cnt_q, cnt_d;
   logic [21:0] len_q, len_d;
   logic [7:0] div_q, div_d;
   logic tick_q, tick_d;
   logic done_q, done_d;
   adc_path_pkg::path_t path_q, path_d;
   logic [1:0] osc_q, osc_d;

   logic [5:0] idx;
   logic acc, wr;
   logic conflict;
   logic [2:0] first_ch, last_ch, nxt_ch;
   logic scan_en;

   assign idx = PADDR[7:2];
   assign acc = PSEL & PENABLE & ~pready_q;
   assign wr = PSEL & PENABLE & pready_q & PWRITE;
   assign scan_en = scan_q[3];
   assign first_ch = scan_q[2:0] > 3'h6 ? 3'h6 : scan_q[2:0];
   assign last_ch = scan_q[6:4] > 3'h6 ? 3'h6 : scan_q[6:4];
   assign nxt_ch = next_chan(ch_q, first_ch, last_ch);

   // the host owns this; we only flag it in status
   always_comb begin
      conflict = 1'b0;
      for (int i = 0; i < `NUM_CH; i++) begin
         if (inctl_q[i].ref_two) begin
            for (int j = 0; j < `NUM_CH; j++) begin
               if (inctl_q[j].pos >= 3'h6 || inctl_q[j].neg >= 3'h6) begin
                  conflict = 1'b1;
               end
            end
         end
      end
   end

   // apb slave: answer one cycle into the access phase
   always_comb begin
      inctl_d = inctl_q;
      cfg_d = cfg_q;
      clk_d = clk_q;
      cal_d = cal_q;
      scan_d = scan_q;
      gout_d = gout_q;
      goe_d = goe_q;
      pready_d = acc;
      prdata_d = 32'h00000000;
      slverr_d = 1'b0;
      if (acc) begin
         if (is_inctl(idx)) begin
            prdata_d = 32'(inctl_q[idx[2:0]]);
         end else if (is_cfg(idx)) begin
            prdata_d = 32'(cfg_q[idx[2:0]]);
         end else begin
            unique case (idx)
               `IDX_CLK: prdata_d = 32'(clk_q);
               `IDX_CAL: prdata_d = 32'(cal_q);
               `IDX_SCAN: prdata_d = 32'(scan_q);
               `IDX_GOUT: prdata_d = 32'(gout_q);
               `IDX_GOE: prdata_d = 32'(goe_q);
               `IDX_GIN: prdata_d = 32'(pin_q[6:0]);
               `IDX_STAT: prdata_d = 32'({conflict, pin_q[7], st_q == adc_path_pkg::SEQ_CONV, ch_q});
               default: slverr_d = 1'b1;
            endcase
         end
      end
      if (wr) begin
         if (is_inctl(idx)) begin
            inctl_d[idx[2:0]] = PWDATA[`FIELD_W-1:0];
         end else if (is_cfg(idx)) begin
            cfg_d[idx[2:0]] = PWDATA[`FIELD_W-1:0];
         end else begin
            unique case (idx)
               `IDX_CLK: clk_d = PWDATA[1:0];
               `IDX_CAL: cal_d = PWDATA[1:0];
               `IDX_SCAN: scan_d = PWDATA[7:0];
               `IDX_GOUT: gout_d = PWDATA[6:0];
               `IDX_GOE: goe_d = PWDATA[6:0];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         for (int i = 0; i < `NUM_CH; i++) begin
            inctl_q[i] <= `RST_INCTL;
            cfg_q[i] <= `RST_CFG;
         end
         clk_q <= 2'h0;
         cal_q <= 2'h0;
         scan_q <= `RST_SCAN;
         gout_q <= 7'h00;
         goe_q <= 7'h00;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
      end else begin
         inctl_q <= inctl_d;
         cfg_q <= cfg_d;
         clk_q <= clk_d;
         cal_q <= cal_d;
         scan_q <= scan_d;
         gout_q <= gout_d;
         goe_q <= goe_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         slverr_q <= slverr_d;
      end
   end

   // three stages; a level counts once stages two and three agree
   always_comb begin
      pin_d = pin_q;
      for (int i = 0; i < 8; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            pin_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         pin_q <= 8'h00;
      end else begin
         s1_q <= {XTAL_SEEN, GPIO_IN};
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   // clock choice: bit0 external, bit1 detection mode
   always_comb begin
      osc_d[1] = clk_q[0] | (clk_q[1] & pin_q[7]);
      osc_d[0] = ~osc_d[1];
   end

   // converter tick; filter and rate timing all count it, so they scale together
   always_comb begin
      div_d = div_q + 8'h01;
      tick_d = 1'b0;
      if (div_q == 8'(TICK_DIV - 1)) begin
         div_d = 8'h00;
         tick_d = 1'b1;
      end
   end

   always_comb begin
      st_d = st_q;
      ch_d = ch_q;
      cnt_d = cnt_q;
      len_d = len_q;
      done_d = 1'b0;
      path_d = path_q;
      path_d.cal_mode = cal_q;
      unique case (st_q)
         adc_path_pkg::SEQ_IDLE: begin
            if (scan_en) begin
               st_d = adc_path_pkg::SEQ_CONV;
               ch_d = first_ch;
            end
         end
         adc_path_pkg::SEQ_CONV: begin
            if (tick_q) begin
               cnt_d = cnt_q + 22'h000001;
               if (cnt_q == len_q - 22'h000001) begin
                  done_d = 1'b1;
                  cnt_d = 22'h000000;
                  ch_d = nxt_ch;
                  if (!scan_en) begin
                     st_d = adc_path_pkg::SEQ_IDLE;
                  end
               end
            end
         end
      endcase
      // latch at a conversion start only, never mid-conversion
      if (st_d == adc_path_pkg::SEQ_CONV && (st_q == adc_path_pkg::SEQ_IDLE || done_d)) begin
         path_d.chan = ch_d;
         path_d.sel = inctl_q[ch_d];
         path_d.fixed_on = gain_fixed(cfg_q[ch_d].gain);
         path_d.programmable_gain_stage = cfg_q[ch_d].gain[1:0];
         path_d.buf_on = buf_need(cfg_q[ch_d]);
         path_d.rate = cfg_q[ch_d].rate;
         path_d.line_reject = cfg_q[ch_d].rate <= `RATE_SLOW_MAX;
         path_d.cal_active = ch_d < 3'(`NUM_DIFF_CH);
         len_d = conv_len(cfg_q[ch_d].rate);
      end
      // correction runs beside conversion, so the sequence never pauses for it
      if (cal_q == adc_path_pkg::CAL_OFF) begin
         path_d.cal_active = 1'b0;
      end else if (st_q == adc_path_pkg::SEQ_CONV) begin
         // the channel just latched, not the one that is finishing
         path_d.cal_active = path_d.chan < 3'(`NUM_DIFF_CH);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_q <= adc_path_pkg::SEQ_IDLE;
         ch_q <= 3'h0;
         cnt_q <= 22'h000000;
         len_q <= 22'h000001;
         div_q <= 8'h00;
         tick_q <= 1'b0;
         done_q <= 1'b0;
         path_q <= '0;
         osc_q <= 2'h1;
      end else begin
         st_q <= st_d;
         ch_q <= ch_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
         div_q <= div_d;
         tick_q <= tick_d;
         done_q <= done_d;
         path_q <= path_d;
         osc_q <= osc_d;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = slverr_q;
   assign GPIO_OUT = gout_q;
   assign GPIO_OE = goe_q;
   assign INT_OSC_ON = osc_q[0];
   assign EXT_CLK_USE = osc_q[1];
   assign PATH = path_q;
   assign CONV_DONE = done_q;

   default clocking dc @(posedge CLOCK); endclocking
   default disable iff (RST);

   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("pready longer than one cycle");
   buf_forced_a: assert property (PATH.fixed_on |-> PATH.buf_on)
      else $error("buffer missing at high gain");
   hold_mid_a: assert property (st_q == adc_path_pkg::SEQ_CONV && !done_q ##1 !done_q
      |-> $stable(PATH.sel) && $stable(PATH.rate))
      else $error("settings changed mid conversion");
   osc_off_a: assert property (clk_q == 2'h2 && pin_q[7] |=> !INT_OSC_ON && EXT_CLK_USE)
      else $error("internal oscillator not stopped");
   reject_a: assert property (PATH.line_reject |-> PATH.rate <= 3'h3)
      else $error("line rejection flagged at fast rate");
   cal_scope_a: assert property (PATH.cal_active |-> PATH.chan < 3'h4 && PATH.cal_mode != 2'h0)
      else $error("calibration outside diff channels");
   chan_range_a: assert property (PATH.chan <= 3'h6)
      else $error("channel above six");
   advance_a: assert property (done_d && scan_en |=> ch_q == $past(nxt_ch))
      else $error("scan did not advance");
   gpio_write_a: assert property (PSEL && PENABLE && PREADY && PWRITE && idx == 6'h13
      |=> GPIO_OUT == $past(PWDATA[6:0]))
      else $error("gpio write lost");
   gain_map_a: assert property (done_q |-> PATH.fixed_on == (cfg_q[PATH.chan].gain >= 3'h4)
      || !$stable(cfg_q[PATH.chan]))
      else $error("fixed stage mismatch");

   // loads at a start must come from the registers of the channel starting
   scan_wrap_a: assert property (done_d && scan_en && ch_q == last_ch |=> ch_q == $past(first_ch))
      else $error("scan did not wrap to first channel");
   cal_off_a: assert property (cal_q == 2'h0 |=> !PATH.cal_active)
      else $error("calibration active while off");
   osc_int_a: assert property (clk_q == 2'h0 |=> INT_OSC_ON && !EXT_CLK_USE)
      else $error("internal oscillator not selected");
   osc_ext_a: assert property (clk_q[0] |=> !INT_OSC_ON && EXT_CLK_USE)
      else $error("external clock not selected");
   rate_len_a: assert property (done_q |-> len_q == conv_len(PATH.rate))
      else $error("conversion length does not match rate");
   gpio_oe_a: assert property (PSEL && PENABLE && PREADY && PWRITE && idx == `IDX_GOE
      |=> GPIO_OE == $past(PWDATA[6:0]))
      else $error("gpio enable write lost");
   sel_load_a: assert property (done_q && st_q == adc_path_pkg::SEQ_CONV
      |-> PATH.sel == $past(inctl_q[ch_d]))
      else $error("input selection not loaded");
   pga_map_a: assert property (done_q && st_q == adc_path_pkg::SEQ_CONV
      |-> PATH.programmable_gain_stage == $past(cfg_q[ch_d].gain[1:0]))
      else $error("programmable stage mismatch");
   buf_choice_a: assert property (done_q && st_q == adc_path_pkg::SEQ_CONV && !PATH.fixed_on
      |-> PATH.buf_on == $past(cfg_q[ch_d].buf_en))
      else $error("buffer choice ignored at low gain");

   scan_cov_c: cover property (done_q ##1 PATH.chan != $past(PATH.chan));
   ref2_cov_c: cover property (done_q && PATH.sel.ref_two);
   err_cov_c: cover property (PSLVERR);
   wrap_cov_c: cover property (done_q && PATH.chan == 3'h0 && $past(PATH.chan) == 3'h6);
   ext_cov_c: cover property (clk_q == 2'h2 && EXT_CLK_USE);
endmodule
`default_nettype wire

// file: verification/host_apb.sv
`timescale 1ns/1ps
`default_nettype none
module host_apb (
   input wire logic clock,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // request held until pready seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, output logic to);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      to = (n >= 50);
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show garbage, not the last value
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, done, osc, ext, xtal;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] gin_ext, gout, goe, gpin;
   adc_path_pkg::path_t path;
   int num_errors = 0;
   int checks = 0;
   logic [7:0] lf = 8'h21;
   logic [6:0] in_v, cf;
   logic [2:0] g, rt;
   logic [2:0] c;
   int n;

   always #2.5 clk = ~clk;
   // pin level: device drives where enabled, outside world elsewhere
   assign gpin = (goe & gout) | (~goe & gin_ext);

   host_apb host (.clock(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   adc_path_cfg #(.TICK_DIV(2), .CONV_SLOW(8), .CONV_FAST(4)) dut (.CLOCK(clk), .RST(rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .XTAL_SEEN(xtal),
      .GPIO_IN(gpin), .GPIO_OUT(gout), .GPIO_OE(goe), .INT_OSC_ON(osc),
      .EXT_CLK_USE(ext), .PATH(path), .CONV_DONE(done));

   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   // inputs six and seven share pins with reference two
   function automatic logic [2:0] pick(input logic r, input logic [2:0] v);
      return (r && v > 3'h5) ? v - 3'h2 : v;
   endfunction

   // clocks per conversion with tick divider 2
   function automatic int conv_cyc(input logic [2:0] r);
      return (r[2] ? 8 : 16) << (3 - r[1:0]);
   endfunction

   task automatic report_and_stop;
      if (num_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      checks++;
      if (v !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
      end
   endtask

   task automatic tmo;
      chk("timeout", 0, 1);
      report_and_stop;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e, to;
      host.xfer(1'b1, a, d, r, e, to);
      if (to)
         tmo;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e, to;
      host.xfer(1'b0, a, 32'h00000000, r, e, to);
      if (to)
         tmo;
      chk("prdata", x, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask

   task automatic wait_done(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (done !== 1'b1 && k < 400);
      if (k >= 400)
         tmo;
   endtask

   initial begin
      xtal <= 1'b0;
      gin_ext <= 7'h55;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("rst_path", 32'h00000000, 32'(path));
      chk("rst_pins", 32'h00000002, {15'h0000, gout, goe, done, osc, ext});
      rd(8'h00, 32'h00, 1'b0);
      rd(8'h20, 32'h70, 1'b0);
      rd(8'hFC, 32'h00, 1'b1);
      wr(8'h48, 32'h08);
      // first eight pass every gain and rate code once
      for (int i = 0; i < 14; i++) begin
         lf = nxt(lf);
         in_v = {lf[7], pick(lf[7], lf[5:3]), pick(lf[7], lf[2:0])};
         lf = nxt(lf);
         g = (i < 8) ? 3'(i) : lf[2:0];
         rt = (i < 8) ? 3'(i) : lf[5:3];
         cf = {rt, g, lf[6]};
         wr(8'h00, {25'h0, in_v});
         wr(8'h20, {25'h0, cf});
         if (i == 1)
            chk("gain_hold", 0, {path.fixed_on, path.programmable_gain_stage});
         rd(8'h00, {25'h0, in_v}, 1'b0);
         rd(8'h20, {25'h0, cf}, 1'b0);
         wait_done(n);
         wait_done(n);
         chk("len", conv_cyc(rt), n);
         chk("sel", in_v, path.sel);
         chk("gain", {g >= 3'h4, g[1:0]}, {path.fixed_on, path.programmable_gain_stage});
         chk("buf", cf[0] | (g >= 3'h4), path.buf_on);
         chk("rate", rt, path.rate);
         chk("lrej", rt <= 3'h3, path.line_reject);
      end
      wr(8'h48, 32'h48);
      wait_done(n);
      c = path.chan;
      for (int k = 1; k < 9; k++) begin
         wr(8'h44, k % 4);
         wait_done(n);
         c = (c == 3'h4) ? 3'h0 : c + 3'h1;
         chk("chan", c, path.chan);
         chk("cal", k % 4, path.cal_mode);
         chk("cal_on", (k % 4 != 0) && c < 3'h4, path.cal_active);
      end
      // first above last: the scan runs through six and wraps to zero
      wr(8'h48, 32'h1D);
      wait_done(n);
      c = path.chan;
      for (int k = 0; k < 6; k++) begin
         wait_done(n);
         c = (c == 3'h1) ? 3'h5 : (c == 3'h6) ? 3'h0 : c + 3'h1;
         chk("wrap", c, path.chan);
      end
      wr(8'h40, 32'h02);
      repeat (8) @(posedge clk);
      chk("osc", 1, osc);
      chk("ext", 0, ext);
      xtal <= 1'b1;
      repeat (8) @(posedge clk);
      chk("osc", 0, osc);
      chk("ext", 1, ext);
      xtal <= 1'b0;
      wr(8'h40, 32'h01);
      repeat (8) @(posedge clk);
      chk("osc_forced", 0, osc);
      chk("ext_forced", 1, ext);
      wr(8'h4C, 32'h2A);
      wr(8'h50, 32'h0F);
      chk("gout", 7'h2A, gout);
      chk("goe", 7'h0F, goe);
      repeat (4) @(posedge clk);
      rd(8'h54, (7'h0F & 7'h2A) | (7'h70 & 7'h55), 1'b0);
      report_and_stop;
   end
endmodule
`default_nettype wire
